/* i2c_fsr_pkg.sv */
// Purpose: Shared constants and types for the filter, stop and range block.
// Assumes: Eight-bit registers on a plain strobe port.
// Notes:   Offsets are register indexes on the local port.
package i2c_fsr_pkg;

	localparam logic [3:0] FLT_OFS       = 4'h6;
	localparam logic [3:0] RA_OFS        = 4'h7;
	localparam logic [3:0] MATCH_CFG_OFS = 4'h8;
	localparam logic [3:0] STATUS_OFS    = 4'h9;

	localparam int STOP_HOLDOFF_ENABLE_BIT   = 7;
	localparam int BUS_STOP_FLAG_BIT  = 6;
	localparam int BUS_STOP_IRQ_ENABLE_BIT = 5;
	localparam int FLTW       = 5;

	localparam logic [7:0] FLT_RST = 8'h00;
	localparam logic [6:0] RA_RST  = 7'h00;
	localparam logic [6:0] A1_RST  = 7'h00;

	typedef struct packed {
		logic [3:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
	} reg_req_t;

	typedef enum logic [1:0] {
		RUN,
		HOLD,
		STOPPED
	} stop_state_t;

endpackage : i2c_fsr_pkg

/* i2c_filter_stop_range.sv */
// Purpose: Input glitch filter, stop hold-off, stop detection and range
//          slave address matching of an I2C controller.
// Assumes: Bus pins arrive synchronous to clk_sys.
// Notes:   Index 8 holds the own address, index 9 the status bits.
// Function
// - Hold-off on: delay stop acknowledge until current byte finishes.
// - Hold-off on: acknowledge stop on the next clock when idle or disabled.
// - Hold-off off: never gate or delay stop entry.
// - Module irq enable set before stop: raise transfer-complete irq on wake.
// - Stop condition sets stop flag; write one clears, zero ignored.
// - Stop interrupt requested only while stop irq enable set.
// - Stop flag still set with stop irq enable set when module flag cleared reasserts module flag.
// - Filter width counts bus clocks; zero bypasses filter.
// - Setting n blocks pulses of n or fewer bus clocks.
// - Range address holds seven-bit address in upper seven bits.
// - Nonzero write to range address enables it for matching.
// - Range address is inclusive upper limit when range matching on.
// - Range register bit zero is reserved and reads zero.
// - Range match: address above primary and at or below range address.
//
// The implementer's own choice: the strobed register port.
module i2c_filter_stop_range
	import i2c_fsr_pkg::*;
(
	// Clock and reset.
	input  wire logic        clk_sys,
	input  wire logic        srst,
	// Register port.
	input  wire logic [3:0]  reg_addr,
	input  wire logic [7:0]  reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic      [7:0]  reg_rdata,
	// Raw bus inputs and filtered outputs.
	input  wire logic        scl_in,
	input  wire logic        sda_in,
	output logic             scl_filt,
	output logic             sda_filt,
	// Controller context.
	input  wire logic        module_enable,
	input  wire logic        xfer_busy,
	input  wire logic        byte_done,
	input  wire logic        module_irq_enable,
	input  wire logic        module_irq_flag_clear,
	input  wire logic [6:0]  rx_address,
	// Stop mode handshake.
	input  wire logic        stop_req,
	output logic             stop_ack,
	// Results.
	output logic             addr_match,
	output logic             module_irq_flag,
	output logic             transfer_complete_flag,
	output logic             stop_irq_req
);
	import i2c_fsr_pkg::*;

	logic [7:0]  flt_r;
	logic [6:0]  range_upper_address_r;
	logic        range_en_r;
	logic        range_match_enable_r;
	logic [6:0]  primary_own_address_r;
	logic        scl_f_r;
	logic        sda_f_r;
	logic        scl_f_d_r;
	logic        sda_f_d_r;
	logic        bus_stop_flag_r;
	logic        irq_flag_r;
	logic        tcf_r;
	logic        irq_armed_r;
	logic        wake_irq_r;
	stop_state_t st_r;
	logic [FLTW-1:0] scl_cnt_r;
	logic [FLTW-1:0] sda_cnt_r;
	logic        stop_seen;
	logic        wr_flt;
	logic        wr_ra;
	logic        wr_cfg;
	logic        wr_status;

	// Counts the samples in which the raw line differs from its accepted level.
	function automatic logic [FLTW-1:0] filt_cnt(
		input logic [FLTW-1:0] cnt,
		input logic            raw,
		input logic            filt
	);
		filt_cnt = (raw == filt) ? '0 : cnt + 1'b1;
	endfunction : filt_cnt

	//--------------------------------------------------------------
	// Register writes.
	//--------------------------------------------------------------
	always_comb
	begin
		wr_flt = 1'b0;
		wr_ra = 1'b0;
		wr_cfg = 1'b0;
		wr_status = 1'b0;
		if (reg_wr && reg_addr == FLT_OFS)
			wr_flt = 1'b1;
		else if (reg_wr && reg_addr == RA_OFS)
			wr_ra = 1'b1;
		else if (reg_wr && reg_addr == MATCH_CFG_OFS)
			wr_cfg = 1'b1;
		else if (reg_wr && reg_addr == STATUS_OFS)
			wr_status = 1'b1;
	end

	always_ff @(posedge clk_sys)
	begin
		if (srst)
			flt_r <= FLT_RST;
		else if (wr_flt)
			flt_r <= reg_wdata;
	end

	// Any nonzero write enables the range register for matching.
	always_ff @(posedge clk_sys)
	begin
		if (srst)
		begin
			range_upper_address_r <= RA_RST;
			range_en_r <= 1'b0;
		end
		else if (wr_ra)
		begin
			range_upper_address_r <= reg_wdata[7:1];
			range_en_r <= (reg_wdata != 8'h00);
		end
	end

	// The own match register holds the primary address and the range mode.
	always_ff @(posedge clk_sys)
	begin
		if (srst)
		begin
			range_match_enable_r <= 1'b0;
			primary_own_address_r <= A1_RST;
		end
		else if (wr_cfg)
		begin
			range_match_enable_r <= reg_wdata[0];
			primary_own_address_r <= reg_wdata[7:1];
		end
	end

	//--------------------------------------------------------------
	// Glitch filter.
	//--------------------------------------------------------------
	// A level is accepted once it has differed for more than n clocks.
	always_ff @(posedge clk_sys)
	begin
		if (srst)
		begin
			scl_cnt_r <= '0;
			sda_cnt_r <= '0;
			scl_f_r <= 1'b1;
			sda_f_r <= 1'b1;
		end
		else if (flt_r[FLTW-1:0] == '0)
		begin
			scl_cnt_r <= '0;
			sda_cnt_r <= '0;
			scl_f_r <= scl_in;
			sda_f_r <= sda_in;
		end
		else
		begin
			scl_cnt_r <= filt_cnt(scl_cnt_r, scl_in, scl_f_r);
			sda_cnt_r <= filt_cnt(sda_cnt_r, sda_in, sda_f_r);
			if (scl_in != scl_f_r && scl_cnt_r >= flt_r[FLTW-1:0])
			begin
				scl_f_r <= scl_in;
				scl_cnt_r <= '0;
			end
			if (sda_in != sda_f_r && sda_cnt_r >= flt_r[FLTW-1:0])
			begin
				sda_f_r <= sda_in;
				sda_cnt_r <= '0;
			end
		end
	end

	assign scl_filt = scl_f_r;
	assign sda_filt = sda_f_r;

	//--------------------------------------------------------------
	// Stop detection and flags.
	//--------------------------------------------------------------
	always_ff @(posedge clk_sys)
	begin
		if (srst)
		begin
			scl_f_d_r <= 1'b1;
			sda_f_d_r <= 1'b1;
		end
		else
		begin
			scl_f_d_r <= scl_f_r;
			sda_f_d_r <= sda_f_r;
		end
	end

	// A stop is data rising while the clock has been high for two samples.
	assign stop_seen = scl_f_r && scl_f_d_r && sda_f_r && !sda_f_d_r;

	// Detection wins over a simultaneous clear.
	always_ff @(posedge clk_sys)
	begin
		if (srst)
			bus_stop_flag_r <= 1'b0;
		else if (stop_seen)
			bus_stop_flag_r <= 1'b1;
		else if (wr_flt && reg_wdata[BUS_STOP_FLAG_BIT])
			bus_stop_flag_r <= 1'b0;
	end

	assign stop_irq_req = bus_stop_flag_r && flt_r[BUS_STOP_IRQ_ENABLE_BIT];

	// The module flag is re-set while a gated stop flag is pending.
	always_ff @(posedge clk_sys)
	begin
		if (srst)
			irq_flag_r <= 1'b0;
		else if (stop_irq_req || (stop_seen && flt_r[BUS_STOP_IRQ_ENABLE_BIT]))
			irq_flag_r <= 1'b1;
		else if (wake_irq_r)
			irq_flag_r <= 1'b1;
		else if (module_irq_flag_clear)
			irq_flag_r <= 1'b0;
	end

	assign module_irq_flag = irq_flag_r;

	//--------------------------------------------------------------
	// Stop mode hold-off.
	//--------------------------------------------------------------
	// Hold-off waits for the byte in flight; an idle or disabled module
	// goes straight to the stopped state on the next clock.
	always_ff @(posedge clk_sys)
	begin
		if (srst)
			st_r <= RUN;
		else
			case (st_r)
				RUN:
					if (stop_req)
					begin
						if (flt_r[STOP_HOLDOFF_ENABLE_BIT] && module_enable && xfer_busy
						    && !byte_done)
							st_r <= HOLD;
						else
							st_r <= STOPPED;
					end
				HOLD:
					if (!stop_req)
						st_r <= RUN;
					else if (byte_done || !xfer_busy)
						st_r <= STOPPED;
				STOPPED:
					if (!stop_req)
						st_r <= RUN;
				default:
					st_r <= RUN;
			endcase
	end

	// Without hold-off the acknowledge follows the request directly.
	assign stop_ack = flt_r[STOP_HOLDOFF_ENABLE_BIT] ? (st_r == STOPPED)
	                                  : stop_req;

	// The module interrupt enable is latched while the acknowledge stands,
	// and leaving stop mode turns it into a one-cycle wake pulse.
	always_ff @(posedge clk_sys)
	begin
		if (srst)
		begin
			irq_armed_r <= 1'b0;
			wake_irq_r <= 1'b0;
		end
		else
		begin
			wake_irq_r <= 1'b0;
			if (stop_req && stop_ack && !irq_armed_r)
				irq_armed_r <= module_irq_enable;
			else if (!stop_req && irq_armed_r)
			begin
				irq_armed_r <= 1'b0;
				wake_irq_r <= 1'b1;
			end
		end
	end

	// A byte end or a wake sets the complete flag; a busy bus clears it.
	always_ff @(posedge clk_sys)
	begin
		if (srst)
			tcf_r <= 1'b0;
		else if (byte_done || wake_irq_r)
			tcf_r <= 1'b1;
		else if (xfer_busy)
			tcf_r <= 1'b0;
	end

	assign transfer_complete_flag = tcf_r;

	//--------------------------------------------------------------
	// Address matching.
	//--------------------------------------------------------------
	// The range register matches on its own like the primary address, and
	// with range matching on it also bounds the range from above.
	always_comb
	begin
		addr_match = (rx_address == primary_own_address_r);
		if (range_en_r && rx_address == range_upper_address_r)
			addr_match = 1'b1;
		if (range_match_enable_r && range_en_r
		    && rx_address > primary_own_address_r
		    && rx_address <= range_upper_address_r)
			addr_match = 1'b1;
	end

	//--------------------------------------------------------------
	// Register reads.
	//--------------------------------------------------------------
	// Read data stand in the cycle after each cycle that reg_rd is high and are zero otherwise.
	always_ff @(posedge clk_sys)
	begin
		if (srst)
			reg_rdata <= 8'h00;
		else if (!reg_rd)
			reg_rdata <= 8'h00;
		else if (reg_addr == FLT_OFS)
			reg_rdata <= {flt_r[STOP_HOLDOFF_ENABLE_BIT], bus_stop_flag_r,
			              flt_r[BUS_STOP_IRQ_ENABLE_BIT], flt_r[FLTW-1:0]};
		else if (reg_addr == RA_OFS)
			reg_rdata <= {range_upper_address_r, 1'b0};
		else if (reg_addr == MATCH_CFG_OFS)
			reg_rdata <= {primary_own_address_r, range_match_enable_r};
		else if (reg_addr == STATUS_OFS)
			reg_rdata <= {4'h0, range_en_r, tcf_r, irq_flag_r, stop_ack};
		else
			reg_rdata <= 8'h00;
	end

endmodule : i2c_filter_stop_range

/* fsr_chk_sva.sv */
// Purpose: Port assertions for the filter, stop and range block.
// Assumes: Every register write is visible on the port.
// Notes:   Shadow copies of the control fields follow the writes.
module fsr_chk
	import i2c_fsr_pkg::*;
(
	input wire logic       clk_sys,
	input wire logic       srst,
	input wire logic [3:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic       reg_wr,
	input wire logic       sda_in,
	input wire logic       scl_filt,
	input wire logic       sda_filt,
	input wire logic       module_enable,
	input wire logic       xfer_busy,
	input wire logic       byte_done,
	input wire logic       module_irq_enable,
	input wire logic [6:0] rx_address,
	input wire logic       stop_req,
	input wire logic       stop_ack,
	input wire logic       addr_match,
	input wire logic       module_irq_flag,
	input wire logic       transfer_complete_flag,
	input wire logic       stop_irq_req
);
	logic [7:0] flt_r;
	logic [6:0] ra_r;
	logic [6:0] a1_r;
	logic       rm_r;
	logic [5:0] dc_r;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (srst);
	always_ff @(posedge clk_sys)
	begin
		if (srst)
		begin
			flt_r <= 8'h00;
			ra_r  <= 7'h00;
			{a1_r, rm_r} <= 8'h00;
		end
		else if (reg_wr && reg_addr == FLT_OFS)
			flt_r <= reg_wdata;
		else if (reg_wr && reg_addr == RA_OFS)
			ra_r <= reg_wdata[7:1];
		else if (reg_wr && reg_addr == MATCH_CFG_OFS)
			{a1_r, rm_r} <= reg_wdata;
	end
	// Counts consecutive samples in which raw and filtered data differ.
	always_ff @(posedge clk_sys)
		if (srst || sda_in == sda_filt)
			dc_r <= 6'h00;
		else if (dc_r != 6'h3f)
			dc_r <= dc_r + 6'h01;
	property p_off; !flt_r[7] && stop_req |-> stop_ack; endproperty
	a_off: assert property (p_off) else $error("stop ack gated");
	property p_idle; flt_r[7] && stop_req && !(xfer_busy && module_enable)
		|=> stop_ack || !stop_req; endproperty
	a_idle: assert property (p_idle) else $error("idle ack late");
	property p_hold; flt_r[7] && stop_req && !stop_ack && xfer_busy &&
		module_enable && !byte_done && !$past(byte_done) |=> !stop_ack;
	endproperty
	a_hold: assert property (p_hold) else $error("ack mid byte");
	property p_ie; !flt_r[5] |-> !stop_irq_req; endproperty
	a_ie: assert property (p_ie) else $error("stop irq unmasked");
	property p_ifl; stop_irq_req |=> module_irq_flag; endproperty
	a_ifl: assert property (p_ifl) else $error("irq flag not held");
	property p_det; flt_r[5] && scl_filt && $rose(sda_filt)
		|-> ##[1:4] stop_irq_req; endproperty
	a_det: assert property (p_det) else $error("stop not flagged");
	property p_fwd; !$past(srst) && $changed(sda_filt)
		|-> $past(dc_r) >= {1'b0, $past(flt_r[4:0])}; endproperty
	a_fwd: assert property (p_fwd) else $error("glitch passed");
	property p_byp; flt_r[4:0] == 5'h00 |=> sda_filt == $past(sda_in);
	endproperty
	a_byp: assert property (p_byp) else $error("bypass wrong");
	property p_rng; rm_r && rx_address > a1_r && rx_address <= ra_r
		|-> addr_match; endproperty
	a_rng: assert property (p_rng) else $error("range miss");
	property p_wake; $fell(stop_req) && $past(stop_ack) &&
		$past(module_irq_enable) |-> ##[1:4] transfer_complete_flag;
	endproperty
	a_wake: assert property (p_wake) else $error("no wake irq");
	c_stop: cover property (stop_irq_req);
	c_ack: cover property (flt_r[7] && xfer_busy && stop_ack);
	c_match: cover property (rm_r && addr_match);
endmodule : fsr_chk
bind i2c_filter_stop_range fsr_chk u_chk (.clk_sys, .srst, .reg_addr,
	.reg_wdata, .reg_wr, .sda_in, .scl_filt, .sda_filt, .module_enable,
	.xfer_busy, .byte_done, .module_irq_enable, .rx_address, .stop_req,
	.stop_ack, .addr_match, .module_irq_flag, .transfer_complete_flag,
	.stop_irq_req);

/* i2c_peer.sv */
// Purpose: Other bus agents driving the raw clock and data lines.
// Assumes: Lines idle high through the pull-ups.
// Notes:   The bench calls the tasks.
module i2c_peer
(
	input  wire logic clk_sys,
	output logic      scl,
	output logic      sda
);
	timeunit 1ns;
	timeprecision 100ps;
	initial {scl, sda} = 2'b11;
	task automatic step(input logic c, input logic d);
		@(posedge clk_sys);
		{scl, sda} <= {c, d};
		repeat (7) @(posedge clk_sys);
	endtask : step
	// Data rises while the clock is high.
	task automatic stop();
		step(1'b0, 1'b0);
		step(1'b1, 1'b0);
		step(1'b1, 1'b1);
	endtask : stop
	task automatic glitch(input int n);
		@(posedge clk_sys);
		sda <= 1'b0;
		repeat (n) @(posedge clk_sys);
		sda <= 1'b1;
	endtask : glitch
endmodule : i2c_peer

/* testbench.sv */
// Purpose: Self-checking bench for the filter, stop and range block.
// Assumes: Register port strobes last one cycle.
// Notes:   One task per scenario.
module testbench;
	import i2c_fsr_pkg::*;
	timeunit 1ns;
	timeprecision 100ps;
	logic       clk_sys = 1'b0, srst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
	logic [3:0] reg_addr = 4'h0;
	logic [7:0] reg_wdata = 8'h00, reg_rdata, seen;
	logic       module_enable = 1'b1, xfer_busy = 1'b0, byte_done = 1'b0;
	logic       module_irq_enable = 1'b0, module_irq_flag_clear = 1'b0;
	logic [6:0] rx_address = 7'h00;
	logic       stop_req = 1'b0, stop_ack, addr_match, module_irq_flag;
	logic       scl_in, sda_in, scl_filt, sda_filt;
	logic       transfer_complete_flag, stop_irq_req;
	int         errors = 0;
	int         tests_run = 0;
	always #12.5 clk_sys = ~clk_sys;
	always @(negedge clk_sys) if (sda_filt === 1'b0) seen = 8'h01;
	i2c_peer u_peer (.clk_sys, .scl(scl_in), .sda(sda_in));
	i2c_filter_stop_range u_dut (.clk_sys, .srst, .reg_addr, .reg_wdata,
		.reg_wr, .reg_rd, .reg_rdata, .scl_in, .sda_in, .scl_filt, .sda_filt,
		.module_enable, .xfer_busy, .byte_done, .module_irq_enable,
		.module_irq_flag_clear, .rx_address, .stop_req, .stop_ack,
		.addr_match, .module_irq_flag, .transfer_complete_flag,
		.stop_irq_req);
	task automatic chk(input string s, input logic [7:0] e, g);
		tests_run++;
		if (g !== e)
		begin
			errors++;
			$display("FAIL %s expected %h seen %h", s, e, g);
		end
	endtask : chk
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		{reg_wr, reg_addr, reg_wdata} <= {1'b1, a, d};
		@(posedge clk_sys);
		reg_wr <= 1'b0;
		#1;
	endtask : wr
	task automatic rc(input logic [3:0] a, input logic [7:0] e, input string s);
		@(posedge clk_sys);
		{reg_rd, reg_addr} <= {1'b1, a};
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		#1 chk(s, e, reg_rdata);
	endtask : rc
	task automatic clr();
		@(posedge clk_sys);
		module_irq_flag_clear <= 1'b1;
		@(posedge clk_sys);
		module_irq_flag_clear <= 1'b0;
		#1;
	endtask : clr
	// --------------------------------------------------------------
	// Scenarios
	// --------------------------------------------------------------
	task automatic t_regs();
		rc(FLT_OFS, 8'h00, "filter reset");
		wr(RA_OFS, 8'hff);
		rc(RA_OFS, 8'hfe, "range low bit");
		rc(4'hf, 8'h00, "unmapped read");
		$display("t_regs done");
	endtask : t_regs
	task automatic t_filt();
		wr(FLT_OFS, 8'h03);
		seen = 8'h00;
		u_peer.glitch(3);
		repeat (6) @(posedge clk_sys);
		chk("pulse of width", 8'h00, seen);
		u_peer.glitch(4);
		repeat (6) @(posedge clk_sys);
		chk("pulse above width", 8'h01, seen);
		wr(FLT_OFS, 8'h00);
		seen = 8'h00;
		u_peer.glitch(1);
		repeat (3) @(posedge clk_sys);
		chk("bypass", 8'h01, seen);
		$display("t_filt done");
	endtask : t_filt
	task automatic t_stop();
		wr(FLT_OFS, 8'h40);
		rc(FLT_OFS, 8'h00, "flag cleared");
		u_peer.stop();
		chk("scl idle", 8'h01, 8'(scl_filt));
		rc(FLT_OFS, 8'h40, "stop flag");
		chk("masked", 8'h00, 8'(stop_irq_req));
		wr(FLT_OFS, 8'h20);
		chk("stop irq", 8'h01, 8'(stop_irq_req));
		rc(FLT_OFS, 8'h60, "zero write");
		clr();
		chk("flag again", 8'h01, 8'(module_irq_flag));
		wr(FLT_OFS, 8'h60);
		chk("irq off", 8'h00, 8'(stop_irq_req));
		clr();
		chk("flag off", 8'h00, 8'(module_irq_flag));
		$display("t_stop done");
	endtask : t_stop
	task automatic t_hold();
		wr(FLT_OFS, 8'h80);
		@(posedge clk_sys);
		{xfer_busy, stop_req, module_irq_enable} <= 3'b111;
		repeat (4) @(posedge clk_sys);
		#1 chk("held", 8'h00, 8'(stop_ack));
		@(posedge clk_sys);
		byte_done <= 1'b1;
		@(posedge clk_sys);
		byte_done <= 1'b0;
		@(posedge clk_sys);
		#1 chk("byte end", 8'h01, 8'(stop_ack));
		@(posedge clk_sys);
		{xfer_busy, stop_req} <= 2'b00;
		repeat (4) @(posedge clk_sys);
		#1 chk("wake", 8'h01, 8'(transfer_complete_flag));
		chk("wake irq", 8'h01, 8'(module_irq_flag));
		rc(STATUS_OFS, 8'h0e, "status after wake");
		@(posedge clk_sys);
		{xfer_busy, stop_req} <= 2'b01;
		@(posedge clk_sys);
		#1 chk("idle ack", 8'h01, 8'(stop_ack));
		@(posedge clk_sys);
		stop_req <= 1'b0;
		wr(FLT_OFS, 8'h00);
		@(posedge clk_sys);
		{xfer_busy, stop_req} <= 2'b11;
		#1 chk("no gating", 8'h01, 8'(stop_ack));
		@(posedge clk_sys);
		{xfer_busy, stop_req} <= 2'b00;
		rx_address <= 7'h7f;
		@(posedge clk_sys);
		#1 chk("address resent", 8'h01, 8'(addr_match));
		$display("t_hold done");
	endtask : t_hold
	task automatic t_match();
		wr(MATCH_CFG_OFS, 8'h21);
		wr(RA_OFS, 8'h28);
		for (int i = 'h0e; i < 'h17; i++)
		begin
			@(posedge clk_sys);
			rx_address <= 7'(i);
			@(posedge clk_sys);
			#1 chk("match", 8'(i >= 'h10 && i <= 'h14), 8'(addr_match));
		end
		wr(MATCH_CFG_OFS, 8'h20);
		@(posedge clk_sys);
		rx_address <= 7'h12;
		@(posedge clk_sys);
		#1 chk("range off", 8'h00, 8'(addr_match));
		@(posedge clk_sys);
		rx_address <= 7'h14;
		@(posedge clk_sys);
		#1 chk("range equal", 8'h01, 8'(addr_match));
		$display("t_match done");
	endtask : t_match
	task automatic tally_and_finish();
		$display("tests_run %0d errors %0d", tests_run, errors);
		if (errors == 0 && tests_run > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : tally_and_finish
	initial
	begin
		repeat (3) @(posedge clk_sys);
		srst <= 1'b0;
		t_regs();
		t_filt();
		t_stop();
		t_hold();
		t_match();
		tally_and_finish();
	end
	initial
	begin
		#100us;
		errors++;
		tally_and_finish();
	end
endmodule : testbench
